// ==== logic/scc_pkg.sv ====
package scc_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTL = 10'h0A0;
    localparam logic [IDX_W-1:0] IDX_DIV = 10'h0A1;
    localparam logic [IDX_W-1:0] IDX_STAT = 10'h0A2;
    // Oscillator control register fields
    localparam int CTL_INTEN = 7;
    localparam int CTL_XTLEN = 6;
    localparam int CTL_WDTEN = 5;
    localparam int CTL_PRIMARY_FAIL_DETECT_ENABLE = 4;
    localparam int CTL_WDT_FAIL_DETECT_ENABLE = 3;
    localparam int CTL_FLASH_LOW_POWER_ENABLE = 2;
    localparam int CTL_SEL_HI = 1;
    localparam int CTL_SEL_LO = 0;
    localparam logic [7:0] CTL_RESET = 8'hA0;
    // Status register fields
    localparam int STAT_PFAIL = 0;
    localparam int STAT_WFAIL = 1;
    localparam int STAT_FORCE = 2;
    localparam int STAT_SEL_LO = 3;
    localparam int STAT_LOCK_LO = 5;
    // Divide register values
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] DIV_LOW_POWER = 8'h08;
    localparam logic [7:0] DIV_MIN = 8'h02;
    // Unlock keys
    localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
    localparam logic [7:0] UNLOCK_SECOND = 8'h18;
    // Clock sources
    localparam logic [1:0] SEL_IPO = 2'h0;
    localparam logic [1:0] SEL_XTAL = 2'h1;
    localparam logic [1:0] SEL_WDT = 2'h2;
    // Lock sequencer
    typedef enum logic [1:0] {
        LK_LOCKED = 2'b00,
        LK_HALF = 2'b01,
        LK_OPEN = 2'b10
    } scc_lock_t;
    // Timing
    localparam int CNT_W = 16;
    localparam int ACLK_PERIOD_NS = 50;
    localparam int PRIMARY_FAIL_HZ = 1000;
    localparam int PRIMARY_FAIL_CYCLES = 1000000000 / PRIMARY_FAIL_HZ / ACLK_PERIOD_NS;
    localparam int WDT_FAIL_SYS_CYCLES = 8000;
endpackage

// ==== logic/scc_clk_switch.sv ====
`timescale 1ns/1ps
module scc_clk_switch
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requested source
    input wire logic [1:0] sel,
    // Oscillator levels, already gated by their enables
    input wire logic ipo_lvl,
    input wire logic xtal_lvl,
    input wire logic wdt_lvl,
    // Switched clock
    output logic clk_out,
    output logic [1:0] cur_sel
);
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_DROP = 2'b01,
        SW_PICK = 2'b10
    } scc_sw_phase_t;

    typedef struct packed {
        scc_sw_phase_t phase;
        logic [1:0] cur;
        logic gate;
        logic out;
    } scc_sw_state_t;

    scc_sw_state_t st_reg, st_next;

    function automatic logic lvl_of(input logic [1:0] s, input logic a, input logic b, input logic c);
        lvl_of = (s == SEL_XTAL) ? b : ((s == SEL_WDT) ? c : a);
    endfunction

    // Old clock is parked low before the new one is taken while low, so no phase is cut short
    always_comb
    begin
        st_next = st_reg;
        if (!aresetn)
        begin
            st_next = '0;
            st_next.phase = SW_RUN;
            st_next.cur = SEL_IPO;
            st_next.gate = 1'b1;
        end
        else
        begin
            unique case (st_reg.phase)
                SW_RUN:
                    if (sel != st_reg.cur)
                        st_next.phase = SW_DROP;
                SW_DROP:
                    if (!lvl_of(st_reg.cur, ipo_lvl, xtal_lvl, wdt_lvl))
                    begin
                        st_next.gate = 1'b0;
                        st_next.phase = SW_PICK;
                    end
                SW_PICK:
                    if (!lvl_of(sel, ipo_lvl, xtal_lvl, wdt_lvl))
                    begin
                        st_next.cur = sel;
                        st_next.gate = 1'b1;
                        st_next.phase = SW_RUN;
                    end
                default:
                    st_next.phase = SW_RUN;
            endcase
            st_next.out = st_next.gate & lvl_of(st_next.cur, ipo_lvl, xtal_lvl, wdt_lvl);
        end
    end

    always_ff @(posedge aclk)
    begin
        st_reg <= st_next;
    end

    assign clk_out = st_reg.out;
    assign cur_sel = st_reg.cur;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    switch_low_a: assert property ($changed(st_reg.cur) |-> !st_reg.out && !$past(st_reg.out))
        else $error("source changed while clock high");
endmodule // scc_clk_switch

// ==== logic/scc_clk_div.sv ====
`timescale 1ns/1ps
module scc_clk_div
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Source and ratio
    input wire logic src,
    input wire logic [7:0] div,
    // Divided clock
    output logic clk_out
);
    typedef struct packed {
        logic [7:0] cur_div;
        logic [7:0] cnt;
        logic prev;
        logic out;
    } scc_div_state_t;

    scc_div_state_t st_reg, st_next;
    logic rise;
    logic [7:0] cnt_n;

    assign rise = src & ~st_reg.prev;

    // New ratio is taken only at a period boundary so the output keeps whole phases
    always_comb
    begin
        st_next = st_reg;
        cnt_n = 8'h00;
        if (!aresetn)
        begin
            st_next = '0;
            st_next.cur_div = DIV_RESET;
        end
        else
        begin
            st_next.prev = src;
            if (st_reg.cur_div < DIV_MIN)
            begin
                st_next.out = src;
                if (rise)
                    st_next.cur_div = div;
            end
            else if (rise)
            begin
                cnt_n = (st_reg.cnt == st_reg.cur_div - 8'h01) ? 8'h00 : st_reg.cnt + 8'h01;
                st_next.cnt = cnt_n;
                st_next.out = (cnt_n < (st_reg.cur_div >> 1));
                if (cnt_n == 8'h00)
                    st_next.cur_div = div;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        st_reg <= st_next;
    end

    assign clk_out = st_reg.out;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    div_bypass_a: assert property ($past(st_reg.cur_div) < DIV_MIN |-> st_reg.out == $past(src))
        else $error("undivided clock does not follow source");
    div_hold_a: assert property (st_reg.cur_div >= DIV_MIN && !rise |=> $stable(st_reg.out))
        else $error("divided clock moved without source edge");
endmodule // scc_clk_div

// ==== logic/scc_clock_control.sv ====
`timescale 1ns/1ps
module scc_clock_control
    import scc_pkg::*;
#(
    parameter logic [CNT_W-1:0] PRIMARY_LIMIT = CNT_W'(PRIMARY_FAIL_CYCLES),
    parameter logic [CNT_W-1:0] WDT_LIMIT = CNT_W'(WDT_FAIL_SYS_CYCLES)
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Oscillator levels and strap
    input wire logic ipo_clk_in,
    input wire logic xtal_clk_in,
    input wire logic wdt_clk_in,
    input wire logic low_power_option_bit,
    // Clock outputs and oscillator enables
    output logic sys_clk,
    output logic flash_power_down,
    output logic ipo_enable,
    output logic xtal_enable,
    output logic wdt_enable,
    // Failure exception
    output logic system_exception
);
    typedef struct packed {
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        scc_lock_t lock;
        logic [7:0] ctl;
        logic [7:0] div;
        logic force_wdt;
        logic prim_failed;
        logic wdt_failed;
        logic [CNT_W-1:0] prim_cnt;
        logic [CNT_W-1:0] wdt_cnt;
        logic mux_prev;
        logic sys_prev;
        logic wdt_prev;
        logic flash_pd;
        logic exc;
    } scc_ctrl_state_t;

    scc_ctrl_state_t st_reg, st_next;
    logic mux_clk;
    logic div_clk;
    logic [1:0] active_sel;
    logic [1:0] eff_sel;
    logic wr_fire;
    logic wr_ctl;
    logic wr_div;
    logic wr_stat;
    logic [7:0] wr_byte;
    logic mux_rise;
    logic sys_rise;
    logic wdt_rise;
    logic prim_event;
    logic wdt_event;

    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[ADDR_W-1:2];
    endfunction

    // Reserved select code falls back to the internal oscillator
    function automatic logic [1:0] source_of(input logic frc, input logic [1:0] s);
        source_of = frc ? SEL_WDT : ((s == SEL_XTAL || s == SEL_WDT) ? s : SEL_IPO);
    endfunction

    assign eff_sel = source_of(st_reg.force_wdt, st_reg.ctl[CTL_SEL_HI:CTL_SEL_LO]);
    assign ipo_enable = st_reg.ctl[CTL_INTEN];
    assign xtal_enable = st_reg.ctl[CTL_XTLEN];
    assign wdt_enable = st_reg.ctl[CTL_WDTEN] | st_reg.force_wdt;

    // Disabled oscillators present a dead level to the switch, which the primary detector then sees as failure; the watchdog detector watches the ungated input
    scc_clk_switch u_switch (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(eff_sel),
        .ipo_lvl(ipo_clk_in & ipo_enable),
        .xtal_lvl(xtal_clk_in & xtal_enable),
        .wdt_lvl(wdt_clk_in & wdt_enable),
        .clk_out(mux_clk),
        .cur_sel(active_sel)
    );

    scc_clk_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src(mux_clk),
        .div(st_reg.div),
        .clk_out(div_clk)
    );

    // Bus handshakes and decoded write strobes
    assign awready = ~st_reg.aw_have;
    assign wready = ~st_reg.w_have;
    assign arready = ~st_reg.rvalid;
    assign wr_fire = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid;
    assign wr_byte = st_reg.w_data[7:0];
    assign wr_ctl = wr_fire & st_reg.w_lane0 & (reg_index(st_reg.aw_addr) == IDX_CTL);
    assign wr_div = wr_fire & st_reg.w_lane0 & (reg_index(st_reg.aw_addr) == IDX_DIV);
    assign wr_stat = wr_fire & st_reg.w_lane0 & (reg_index(st_reg.aw_addr) == IDX_STAT);

    // Edge detectors on the switched clock, the system clock and the watchdog input, taken as synchronous
    assign mux_rise = mux_clk & ~st_reg.mux_prev;
    assign sys_rise = div_clk & ~st_reg.sys_prev;
    assign wdt_rise = wdt_clk_in & ~st_reg.wdt_prev;

    // Primary watch is blocked for good once the watchdog oscillator has failed
    assign prim_event = st_reg.ctl[CTL_PRIMARY_FAIL_DETECT_ENABLE] & ~st_reg.wdt_failed & ~mux_rise
                        & (st_reg.prim_cnt == PRIMARY_LIMIT - CNT_W'(1));
    assign wdt_event = st_reg.ctl[CTL_WDT_FAIL_DETECT_ENABLE] & sys_rise & ~wdt_rise
                       & (st_reg.wdt_cnt == WDT_LIMIT - CNT_W'(1));

    always_comb
    begin
        st_next = st_reg;
        if (!aresetn)
        begin
            st_next = '0;
            st_next.lock = LK_LOCKED;
            st_next.ctl = CTL_RESET;
            st_next.ctl[CTL_FLASH_LOW_POWER_ENABLE] = ~low_power_option_bit;
            st_next.div = low_power_option_bit ? DIV_RESET : DIV_LOW_POWER;
        end
        else
        begin
            st_next.mux_prev = mux_clk;
            st_next.sys_prev = div_clk;
            st_next.wdt_prev = wdt_clk_in;
            st_next.exc = 1'b0;
            // Address and data are taken independently
            if (awvalid && awready)
            begin
                st_next.aw_have = 1'b1;
                st_next.aw_addr = awaddr;
            end
            if (wvalid && wready)
            begin
                st_next.w_have = 1'b1;
                st_next.w_data = wdata;
                st_next.w_lane0 = wstrb[0];
            end
            if (st_reg.bvalid && bready)
                st_next.bvalid = 1'b0;
            if (wr_fire)
            begin
                st_next.aw_have = 1'b0;
                st_next.w_have = 1'b0;
                st_next.bvalid = 1'b1;
                st_next.bresp = (reg_index(st_reg.aw_addr) == IDX_CTL || reg_index(st_reg.aw_addr) == IDX_DIV
                                 || reg_index(st_reg.aw_addr) == IDX_STAT) ? RESP_OKAY : RESP_SLVERR;
            end
            // Unlock sequencer; a divide write while open relocks it, other writes elsewhere leave it where it is
            if (wr_ctl)
            begin
                unique case (st_reg.lock)
                    LK_LOCKED:
                        st_next.lock = (wr_byte == UNLOCK_FIRST) ? LK_HALF : LK_LOCKED;
                    LK_HALF:
                        st_next.lock = (wr_byte == UNLOCK_SECOND) ? LK_OPEN
                                     : ((wr_byte == UNLOCK_FIRST) ? LK_HALF : LK_LOCKED);
                    LK_OPEN:
                    begin
                        st_next.ctl = wr_byte;
                        st_next.force_wdt = 1'b0;
                        st_next.lock = LK_LOCKED;
                    end
                    default:
                        st_next.lock = LK_LOCKED;
                endcase
            end
            if (wr_div && st_reg.lock == LK_OPEN)
            begin
                st_next.div = wr_byte;
                st_next.lock = LK_LOCKED;
            end
            if (wr_stat && wr_byte[STAT_PFAIL])
                st_next.prim_failed = 1'b0;
            // Read channel; data registered with the valid
            if (st_reg.rvalid && rready)
                st_next.rvalid = 1'b0;
            if (arvalid && arready)
            begin
                st_next.rvalid = 1'b1;
                st_next.rresp = RESP_OKAY;
                st_next.rdata = '0;
                if (reg_index(araddr) == IDX_CTL)
                    st_next.rdata[7:0] = st_reg.ctl;
                else if (reg_index(araddr) == IDX_DIV)
                    st_next.rdata[7:0] = st_reg.div;
                else if (reg_index(araddr) == IDX_STAT)
                begin
                    st_next.rdata[STAT_PFAIL] = st_reg.prim_failed;
                    st_next.rdata[STAT_WFAIL] = st_reg.wdt_failed;
                    st_next.rdata[STAT_FORCE] = st_reg.force_wdt;
                    st_next.rdata[STAT_SEL_LO +: 2] = active_sel;
                    st_next.rdata[STAT_LOCK_LO +: 2] = st_reg.lock;
                end
                else
                    st_next.rresp = RESP_SLVERR;
            end
            // Primary watch counts bus clocks between switched-clock edges
            if (mux_rise || !st_reg.ctl[CTL_PRIMARY_FAIL_DETECT_ENABLE] || st_reg.wdt_failed)
                st_next.prim_cnt = '0;
            else if (st_reg.prim_cnt != PRIMARY_LIMIT)
                st_next.prim_cnt = st_reg.prim_cnt + CNT_W'(1);
            // Watchdog watch counts system clocks between watchdog edges
            if (wdt_rise || !st_reg.ctl[CTL_WDT_FAIL_DETECT_ENABLE])
                st_next.wdt_cnt = '0;
            else if (sys_rise && st_reg.wdt_cnt != WDT_LIMIT)
                st_next.wdt_cnt = st_reg.wdt_cnt + CNT_W'(1);
            // Failure events override any same-cycle software write
            if (prim_event)
            begin
                st_next.prim_failed = 1'b1;
                st_next.ctl[CTL_PRIMARY_FAIL_DETECT_ENABLE] = 1'b0;
                st_next.exc = 1'b1;
                if (st_reg.ctl[CTL_SEL_HI:CTL_SEL_LO] != SEL_WDT)
                    st_next.force_wdt = 1'b1;
            end
            if (wdt_event)
            begin
                st_next.wdt_failed = 1'b1;
                st_next.ctl[CTL_WDT_FAIL_DETECT_ENABLE] = 1'b0;
                st_next.exc = 1'b1;
            end
            // Flash sleeps through the low phase of each system clock period
            st_next.flash_pd = st_next.ctl[CTL_FLASH_LOW_POWER_ENABLE] & ~div_clk;
        end
    end

    always_ff @(posedge aclk)
    begin
        st_reg <= st_next;
    end

    assign bvalid = st_reg.bvalid;
    assign bresp = st_reg.bresp;
    assign rvalid = st_reg.rvalid;
    assign rdata = st_reg.rdata;
    assign rresp = st_reg.rresp;
    assign sys_clk = div_clk;
    assign flash_power_down = st_reg.flash_pd;
    assign system_exception = st_reg.exc;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence key_first;
        wr_ctl && wr_byte == UNLOCK_FIRST && st_reg.lock == LK_LOCKED;
    endsequence
    // Second key only counts while the first is still held, so a relocking write in between is allowed for
    sequence key_second;
        wr_ctl && wr_byte == UNLOCK_SECOND && st_reg.lock == LK_HALF;
    endsequence

    reset_source_a: assert property ($past(!aresetn) |-> st_reg.ctl[CTL_SEL_HI:CTL_SEL_LO] == SEL_IPO)
        else $error("reset did not select internal oscillator");
    reset_strap_a: assert property ($past(!aresetn && !low_power_option_bit)
                                    |-> st_reg.ctl[CTL_FLASH_LOW_POWER_ENABLE] && st_reg.div == DIV_LOW_POWER)
        else $error("low power strap not applied");
    unlock_pair_a: assert property (key_first ##[1:40] key_second |=> st_reg.lock == LK_OPEN)
        else $error("unlock pair did not open register");
    open_write_a: assert property (wr_ctl && st_reg.lock == LK_OPEN && !prim_event && !wdt_event
                                   |=> st_reg.ctl == $past(wr_byte) && st_reg.lock == LK_LOCKED)
        else $error("open write not stored or not relocked");
    locked_write_a: assert property (wr_ctl && st_reg.lock != LK_OPEN
                                     |=> $stable(st_reg.ctl[7:5]) && $stable(st_reg.ctl[2:0]))
        else $error("locked write changed register");
    other_access_a: assert property (st_reg.lock != LK_OPEN && wr_fire && !wr_ctl |=> $stable(st_reg.lock))
        else $error("other access disturbed unlock");
    primary_fail_a: assert property (prim_event |=> system_exception && !st_reg.ctl[CTL_PRIMARY_FAIL_DETECT_ENABLE]
                                     && st_reg.force_wdt == ($past(st_reg.ctl[1:0]) != SEL_WDT))
        else $error("primary failure handling wrong");
    wdt_fail_a: assert property (wdt_event |=> system_exception && !st_reg.ctl[CTL_WDT_FAIL_DETECT_ENABLE]
                                 && st_reg.wdt_failed && $stable(st_reg.force_wdt))
        else $error("watchdog failure handling wrong");
    primary_blocked_a: assert property (st_reg.wdt_failed |-> !prim_event)
        else $error("primary failure seen after watchdog failure");
    wdt_count_a: assert property (st_reg.ctl[CTL_WDT_FAIL_DETECT_ENABLE] |-> st_reg.wdt_cnt < WDT_LIMIT)
        else $error("watchdog count overran limit");
    flash_sleep_a: assert property (st_reg.ctl[CTL_FLASH_LOW_POWER_ENABLE] && !div_clk |=> flash_power_down || !st_reg.ctl[CTL_FLASH_LOW_POWER_ENABLE])
        else $error("flash not powered down in low phase");
endmodule // scc_clock_control

// ==== sim/scc_clock_control_bench.sv ====
`timescale 1ns/1ps
module scc_clock_control_bench;
    import scc_pkg::*;
    localparam logic [11:0] A_CTL = {IDX_CTL, 2'h0};
    localparam logic [11:0] A_DIV = {IDX_DIV, 2'h0};
    localparam logic [11:0] A_ST = {IDX_STAT, 2'h0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [2:0] en;
    logic awready, wready, bvalid, arready, rvalid, sys_clk, fpd, exc, sys_q;
    logic [1:0] bresp, rresp, rs;
    logic ipo = 1'b0, xtal = 1'b0, wdt = 1'b0, strap = 1'b0;
    logic ipo_run = 1'b1, xtal_run = 1'b1, wdt_run = 1'b1;
    logic [2:0] ph = 3'h0;
    int err_count = 0, cmp_count = 0, cyc = 0, exc_n = 0, rises = 0, fpd_n = 0;

    always #25 aclk = ~aclk;

    scc_clock_control #(.PRIMARY_LIMIT(16'h0028), .WDT_LIMIT(16'h0010)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ipo_clk_in(ipo),
        .xtal_clk_in(xtal), .wdt_clk_in(wdt), .low_power_option_bit(strap), .sys_clk(sys_clk),
        .flash_power_down(fpd), .ipo_enable(en[2]), .xtal_enable(en[1]), .wdt_enable(en[0]),
        .system_exception(exc));

    // Oscillators below aclk/2, each stoppable to fake a dead source; monitors and hang guard
    always @(posedge aclk)
    begin
        ph <= ph + 3'h1;
        ipo <= ipo_run & ph[1];
        xtal <= xtal_run & ph[1];
        wdt <= wdt_run & ph[2];
        sys_q <= sys_clk;
        if (exc === 1'b1) exc_n <= exc_n + 1;
        if (sys_clk === 1'b1 && sys_q === 1'b0) rises <= rises + 1;
        if (fpd === 1'b1) fpd_n <= fpd_n + 1;
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            err_count = err_count + 1;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Handshakes judged mid-cycle, where the combinational readies have settled
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ah, wh, bh;
        bh = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!bh)
        begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = (bvalid === 1'b1);
            rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
    endtask

    task automatic rdr(input logic [11:0] a);
        logic ah, rh;
        rh = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!rh)
        begin
            @(negedge aclk);
            ah = arvalid & arready;
            rh = (rvalid === 1'b1);
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        rdr(a);
        chk(rd, {24'h0, e});
    endtask

    task automatic unlock;
        wr(A_CTL, UNLOCK_FIRST);
        wr(A_CTL, UNLOCK_SECOND);
    endtask

    task automatic rst(input logic s);
        aresetn <= 1'b0;
        strap <= s;
        ipo_run <= 1'b1;
        xtal_run <= 1'b1;
        wdt_run <= 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // Bounded wait; a zero expectation runs the full window
    task automatic wait_exc(input int lim, input int e);
        int n0;
        n0 = exc_n;
        for (int i = 0; i < lim && exc_n == n0; i++) @(posedge aclk);
        chk(32'(exc_n - n0), 32'(e));
    endtask

    task automatic period(input int e);
        int r0, n;
        for (int k = 0; k < 2; k++)
        begin
            r0 = rises;
            n = 0;
            while (rises == r0 && n < 200)
            begin
                @(posedge aclk);
                n++;
            end
        end
        chk(32'(n), 32'(e));
    endtask

    task automatic conclude;
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        rst(1'b0);
        rchk(A_CTL, CTL_RESET | 8'h04);
        rchk(A_DIV, DIV_LOW_POWER);
        wr(A_CTL, 8'h00);
        rchk(A_CTL, 8'hA4);
        wr(A_CTL, UNLOCK_SECOND);
        wr(A_CTL, UNLOCK_FIRST);
        wr(A_CTL, 8'h55);
        rchk(A_CTL, 8'hA4);
        wr(A_CTL, UNLOCK_FIRST);
        rchk(A_ST, 8'h20);
        wr(A_CTL, UNLOCK_SECOND);
        wr(A_CTL, 8'hE4);
        rchk(A_CTL, 8'hE4);
        chk({29'h0, en}, 32'h7);
        wr(A_CTL, 8'hA4);
        rchk(A_CTL, 8'hE4);
        repeat (20) @(posedge aclk);
        rchk(A_ST, 8'h00);
        unlock();
        wr(A_CTL, 8'hE5);
        repeat (20) @(posedge aclk);
        rchk(A_ST, 8'h08);
        unlock();
        wr(A_DIV, 8'h04);
        rchk(A_DIV, 8'h04);
        repeat (40) @(posedge aclk);
        period(16);
        rchk(A_ST, 8'h08);
        chk(32'(fpd_n > 0), 32'h1);
        unlock();
        wr(A_CTL, 8'hED);
        wdt_run <= 1'b0;
        wait_exc(1000, 1);
        rchk(A_CTL, 8'hE5);
        rchk(A_ST, 8'h0A);
        unlock();
        wr(A_CTL, 8'hF5);
        xtal_run <= 1'b0;
        wait_exc(300, 0);
        wr(12'h3FC, 8'h00);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        rst(1'b1);
        rchk(A_CTL, CTL_RESET);
        rchk(A_DIV, DIV_RESET);
        chk({29'h0, en}, 32'h5);
        unlock();
        wr(A_CTL, 8'hB0);
        ipo_run <= 1'b0;
        wait_exc(200, 1);
        rchk(A_CTL, 8'hA0);
        repeat (20) @(posedge aclk);
        rchk(A_ST, 8'h15);
        period(8);
        rst(1'b1);
        unlock();
        wr(A_CTL, 8'hB2);
        wdt_run <= 1'b0;
        wait_exc(200, 1);
        rchk(A_ST, 8'h11);
        conclude();
    end
endmodule // scc_clock_control_bench
